/* inc/sdt_pkg.sv */
/*
 * Shared constants of the module command and data timing block: command
 * codes, mode field layout and fixed cycle delays.
 * Assumes commands arrive as the usual active-low select and strobe lines.
 */
`default_nettype none
package sdt_pkg;
   // ---------------------------------------------------------------
   // Command codes on {row strobe, column strobe, write enable}, low active
   // ---------------------------------------------------------------
   localparam logic [2:0] CMD_ACT  = 3'h3;  // bank_activate_cmd
   localparam logic [2:0] CMD_RD   = 3'h5;  // read
   localparam logic [2:0] CMD_WR   = 3'h4;  // write_cmd
   localparam logic [2:0] CMD_PRE  = 3'h2;  // bank_deactivate_cmd
   localparam logic [2:0] CMD_REF  = 3'h1;  // auto_refresh_cmd
   localparam logic [2:0] CMD_MODE = 3'h0;  // mode_set_cmd

   // ---------------------------------------------------------------
   // Address fields
   // ---------------------------------------------------------------
   localparam int ALL_BANKS_BIT = 10;       // deactivate_all_banks_cmd
   localparam int LAT_LSB       = 4;        // read latency field
   localparam int BL_LSB        = 0;        // burst length code
   localparam logic [2:0] LAT_THREE = 3'h3;

   // ---------------------------------------------------------------
   // Reset values and fixed delays in cycles
   // ---------------------------------------------------------------
   localparam logic       RST_LAT3 = 1'b0;  // latency two
   localparam logic [1:0] RST_BL   = 2'h0;  // one word
   localparam int N_MASK_OUT = 2;           // mask to read word
   localparam int N_HIZ_LAT2 = 2;
   localparam int N_HIZ_LAT3 = 3;

   // Burst progress
   typedef enum logic [1:0] {SDT_IDLE, SDT_READ, SDT_WRITE} sdt_burst_t;
endpackage

`default_nettype wire

/* design/sdt_core.sv */
/*
 * Device side of a two-bank synchronous DRAM module: command decode,
 * clock-enable and select gating, write capture with byte masks, read
 * latency pipeline with output blanking and release on deactivation.
 * Assumes the controller keeps every minimum command spacing; inputs are
 * synchronous to core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

// Contract
// R1 - Everything is sampled and launched on the rising clock edge.
// R2 - Controller uses 15 ns period at latency two, 10 ns at three.
// R3 - Activate to deactivate at least 50 ns, at most 100000 ns.
// R4 - Activate, refresh or self-refresh exit to next row command 80 ns.
// R5 - Activate to read or write at least 20 ns.
// R6 - Auto-closing accesses pick spacing that still meets activate time.
// R7 - Deactivate to next row command at least 30 ns.
// R8 - Activates to different banks at least 30 ns apart.
// R9 - Mode set to next row command at least 20 ns.
// R10 - Auto-closing read end: precharge time less latency minus one.
// R11 - Auto-closing write end: precharge time plus one clock.
// R12 - A burst may be cut by a new command one cycle later.
// R13 - Chip select gates commands in the same cycle.
// R14 - Clock enable acts exactly one cycle after being sampled.
// R15 - One cycle from last write word to next read or write.
// R16 - Byte mask acts on write data of the same cycle.
// R17 - Byte mask blanks read output two cycles later.
// R18 - Outputs released within latency cycles after deactivation.
// R19 - First write word is taken with the write command.
// R20 - One cycle from last write word to a deactivate.
// R21 - First read word valid at the read-latency edge.
// R22 - Controller keeps per-bank timers and blocks early commands; the bench model keeps none and paces commands with fixed idle gaps.
module sdt_core
   import sdt_pkg::*;
#(
   parameter int DQ_W  = 72,
   parameter int ROW_W = 11,
   parameter int COL_W = 9
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // Command pins
   input  wire logic              cke,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic              bank_sel,
   input  wire logic [ROW_W-1:0]  addr,
   // Data pins
   input  wire logic [DQ_W/8-1:0] byte_blank_inputs,
   input  wire logic [DQ_W-1:0]   dq_in,
   output logic      [DQ_W-1:0]   dq_out,
   output logic      [DQ_W/8-1:0] dq_oe
);
   localparam int LANES = DQ_W / 8;
   localparam int AW    = 1 + ROW_W + COL_W;

   // All checks below sample on the rising edge and rest in reset
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [DQ_W-1:0]  mem [2**AW];
   logic             clk_en;
   logic             lat3;
   logic [1:0]       bl_code;
   logic [ROW_W-1:0] open_row [2];
   sdt_burst_t       burst;
   logic             burst_bank;
   logic [COL_W-1:0] burst_col;
   logic [2:0]       burst_left;
   logic [LANES-1:0] mask_q;
   logic [DQ_W-1:0]  pipe1_d;
   logic [DQ_W-1:0]  pipe2_d;
   logic             pipe1_v;
   logic             pipe2_v;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   wire [2:0] cmd     = {ras_n, cas_n, we_n};
   wire       take    = clk_en && !cs_n;  // [R13]
   wire       is_act  = take && cmd == CMD_ACT;
   wire       is_rd   = take && cmd == CMD_RD;
   wire       is_wr   = take && cmd == CMD_WR;
   wire       is_pre  = take && cmd == CMD_PRE;
   wire       is_mode = take && cmd == CMD_MODE;
   wire       kill    = is_pre && (addr[ALL_BANKS_BIT]
                        || bank_sel == burst_bank);  // [R18]

   // Current word slot: a new read or write preempts a running burst
   wire        new_rw   = is_rd || is_wr;  // [R12]
   wire        cont     = clk_en && !kill && burst != SDT_IDLE;
   wire        slot_rd  = is_rd || (cont && !new_rw && burst == SDT_READ);
   wire        slot_wr  = is_wr || (cont && !new_rw && burst == SDT_WRITE);
   wire        slot_bk  = new_rw ? bank_sel : burst_bank;
   wire [COL_W-1:0] slot_col = new_rw ? addr[COL_W-1:0] : burst_col;
   wire [AW-1:0] slot_a = {slot_bk, open_row[slot_bk], slot_col};
   wire [2:0]  bl_words = 3'(({2'h0, 1'b1} << bl_code) - 3'h1);
   wire [2:0]  next_left = new_rw ? bl_words : burst_left - 3'h1;

   // Byte mask expanded to bits; write merges with stored word
   logic [DQ_W-1:0] keep_bits;
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         assign keep_bits[gi*8 +: 8] = {8{byte_blank_inputs[gi]}};
      end
   endgenerate
   wire [DQ_W-1:0] merged = (mem[slot_a] & keep_bits)
                          | (dq_in & ~keep_bits);  // [R16] [R19]

   // ---------------------------------------------------------------
   // Clock enable is registered: effect one cycle after sampling
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin  // [R1]
      if (!nrst) clk_en <= 1'b0;
      else       clk_en <= cke;  // [R14]
   end

   // ---------------------------------------------------------------
   // Mode, open rows and burst progress
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lat3        <= RST_LAT3;
         bl_code     <= RST_BL;
         open_row[0] <= '0;
         open_row[1] <= '0;
         burst       <= SDT_IDLE;
         burst_bank  <= 1'b0;
         burst_col   <= '0;
         burst_left  <= 3'h0;
      end else begin
         if (is_mode) begin
            lat3    <= addr[LAT_LSB +: 3] == LAT_THREE;
            bl_code <= addr[BL_LSB +: 2];
         end
         if (is_act) open_row[bank_sel] <= addr;
         if (kill) begin
            burst <= SDT_IDLE;
         end else if (slot_rd || slot_wr) begin  // [R12]
            burst      <= next_left == 3'h0 ? SDT_IDLE
                        : (slot_rd ? SDT_READ : SDT_WRITE);
            burst_bank <= slot_bk;
            burst_col  <= slot_col + COL_W'(1);
            burst_left <= next_left;
         end
      end
   end

   // ---------------------------------------------------------------
   // Write array, same cycle as the command or burst slot
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (slot_wr) mem[slot_a] <= merged;  // [R19]
   end

   // ---------------------------------------------------------------
   // Read pipeline: word leaves at edge latency-1, valid at latency
   // ---------------------------------------------------------------
   wire [DQ_W-1:0] out_src = lat3 ? pipe2_d : pipe1_d;
   wire            out_v   = lat3 ? pipe2_v : pipe1_v;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pipe1_v <= 1'b0;
         pipe2_v <= 1'b0;
         pipe1_d <= '0;
         pipe2_d <= '0;
         mask_q  <= '0;
         dq_out  <= '0;
         dq_oe   <= '0;
      end else if (kill) begin
         pipe1_v <= 1'b0;  // [R18]
         pipe2_v <= 1'b0;
         dq_oe   <= '0;
      end else if (clk_en) begin
         pipe1_v <= slot_rd;  // [R21]
         pipe1_d <= mem[slot_a];
         pipe2_v <= pipe1_v;
         pipe2_d <= pipe1_d;
         mask_q  <= byte_blank_inputs;
         dq_out  <= out_src;
         dq_oe   <= {LANES{out_v}} & ~mask_q;  // [R17]
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Enabled cycles with no mode change or kill, newest in bit 0
   logic [2:0] steady;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) steady <= 3'h0;
      else       steady <= {steady[1:0], clk_en && !is_mode && !kill};
   end
   wire run2 = &steady[1:0] && clk_en;  // pipeline moved two edges
   wire run3 = &steady && clk_en;       // and three edges

   cke_delay_a: assert property ( // [R14]
      $past(nrst) |-> clk_en == $past(cke))
      else $error("clock enable not delayed by one cycle");
   cs_gate_a: assert property ( // [R13]
      (cs_n || !clk_en) |-> !(new_rw || is_act || is_pre || is_mode))
      else $error("command taken while deselected");
   wr_capture_a: assert property ( // [R19]
      is_wr |-> slot_wr && slot_col == addr[COL_W-1:0])
      else $error("write word not taken with its command");
   wr_mask_a: assert property ( // [R16]
      slot_wr |=> mem[$past(slot_a)] ==
         (($past(dq_in) & ~$past(keep_bits))
         | ($past(mem[slot_a]) & $past(keep_bits))))
      else $error("write byte mask misapplied");
   rd_lat2_a: assert property ( // [R21]
      (|dq_oe && !lat3 && run2) |-> $past(slot_rd, 2))
      else $error("read word out of latency two");
   rd_lat3_a: assert property ( // [R21]
      (|dq_oe && lat3 && run3) |-> $past(slot_rd, 3))
      else $error("read word out of latency three");
   rd_blank_a: assert property ( // [R17]
      run2 |-> (dq_oe & $past(byte_blank_inputs, N_MASK_OUT)) == '0)
      else $error("read byte not blanked two cycles after mask");
   hiz_release_a: assert property ( // [R18]
      kill |-> ##[1:2] dq_oe == '0)
      else $error("outputs not released after deactivation");
   burst_cut_a: assert property ( // [R12]
      (burst != SDT_IDLE && is_rd) |-> slot_rd && !slot_wr)
      else $error("new read did not cut running burst");
endmodule

`default_nettype wire

/* tb/sdt_ctrl_model.sv */
/*
 * Controller model: drives command, mask and write data pins.
 * Assumes a 10 ns clock; the bench paces commands with these gaps.
 */
`timescale 1ns/1ns
`default_nettype none
module sdt_ctrl_model (
   // Clock
   input  wire logic    core_clk,
   // Command pins
   output logic         cke,
   output logic         cs_n,
   output logic [2:0]   cmd,
   output logic         bank_sel,
   output logic [10:0]  addr,
   // Data pins
   output logic [8:0]   mask,
   output logic [71:0]  dq_in
);
   // Minimum spacings in 10 ns cycles, rounded up
   localparam int T_RCD = 2;
   localparam int T_RP  = 3;
   localparam int T_RRD = 3;
   localparam int T_RSA = 2;

   // Idle pins until the first command
   initial begin
      {cke, cs_n, cmd} = 5'h1f;
      {bank_sel, addr, mask, dq_in} = '0;
   end

   // Drive at the falling edge, sampled on the next rising edge
   task automatic send(input logic [2:0] c, input logic s, input logic k,
      input logic b, input logic [10:0] a, input logic [8:0] m,
      input logic [71:0] d);
      @(negedge core_clk);
      {cmd, cs_n, cke, bank_sel, addr, mask, dq_in} <= {c, s, k, b, a, m, d};
   endtask
endmodule
`default_nettype wire

/* tb/sdt_core_tb.sv */
/*
 * Bench for sdt_core: array model predicts every output word.
 * Assumes sdt_pkg and sdt_ctrl_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module sdt_core_tb
   import sdt_pkg::*;
();
   localparam int CL = 3;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cke, cs_n, bank_sel, en;
   logic        ck_last = 1'b1;
   logic [2:0]  cmd;
   logic [10:0] addr;
   logic [8:0]  mask, dq_oe, eo;
   logic [71:0] dq_in, dq_out;
   logic [71:0] mem [int];
   logic [71:0] exp_d [int];
   logic [8:0]  exp_oe [int];
   logic [8:0]  blank [int];
   logic [10:0] open_row [2];
   logic [31:0] rs = 32'h976c;
   int          cyc, n, n_fail, check_count, bl;

   sdt_core #(.DQ_W(72), .ROW_W(11), .COL_W(3)) dut (.core_clk(core_clk),
      .nrst(nrst), .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]),
      .we_n(cmd[0]), .bank_sel(bank_sel), .addr(addr),
      .byte_blank_inputs(mask), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));
   sdt_ctrl_model ctl (.core_clk(core_clk), .cke(cke), .cs_n(cs_n),
      .cmd(cmd), .bank_sel(bank_sel), .addr(addr), .mask(mask),
      .dq_in(dq_in));

   // ------------------------------------------------------------
   // Model helpers
   // ------------------------------------------------------------
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic int key(logic b, int col);
      return int'({b, open_row[b], col[2:0]});
   endfunction
   function automatic logic [71:0] lanes(logic [8:0] m);
      for (int j = 0; j < 9; j++) lanes[j*8 +: 8] = {8{m[j]}};
   endfunction

   task automatic chk_oe(logic [8:0] e, logic [8:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: enable exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_dq(logic [71:0] e, logic [71:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: data exp %h got %h", $time, e, g);
      end
   endtask

   // One command cycle; n is the first cycle after its sampling edge
   task automatic step(logic [2:0] c, logic s, logic k, logic b,
                       logic [10:0] a, logic [8:0] m, logic [71:0] d);
      ctl.send(c, s, k, b, a, m, d);
      n = cyc + 1;
      en = ck_last & ~s;
      ck_last = k;
      blank[n + N_MASK_OUT - 1] = m;
      if (en && c == CMD_ACT) open_row[b] = a;
      if (en && c == CMD_MODE) bl = 1 << a[1:0];
      if (en && c == CMD_RD) for (int i = 0; i < bl; i++) begin
         exp_d[n + CL - 1 + i] = mem[key(b, a + i)];
         exp_oe[n + CL - 1 + i] = 9'h1ff;
      end
      if (en && c == CMD_PRE)
         for (int i = 0; i < 12; i++) exp_oe.delete(n + i);
   endtask
   task automatic nop(logic [8:0] m);
      step(3'h7, 1'b0, 1'b1, 1'b0, 11'h0, m, ~dq_in);
   endtask
   task automatic idle(int k);
      repeat (k) nop('0);
   endtask
   task automatic rd(logic b, logic [10:0] c);
      step(CMD_RD, 1'b0, 1'b1, b, c, '0, ~dq_in);
   endtask
   task automatic wr(logic b, int col, logic [8:0] m0);
      logic [71:0] d;
      logic [8:0]  m;
      for (int i = 0; i < bl; i++) begin
         d = 72'({rnd(), rnd(), rnd()});
         m = m0 & 9'(rnd());
         step(i == 0 ? CMD_WR : 3'h7, 1'b0, 1'b1, b, 11'(col), m, d);
         mem[key(b, col + i)] = (mem[key(b, col + i)] & lanes(m)) |
                                (d & ~lanes(m));
      end
   endtask
   task automatic tend(string s);
      $display("test %s done", s);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Compare enables and data in every settled cycle
   always @(negedge core_clk) begin
      if (nrst) begin
         eo = exp_oe.exists(cyc) ? exp_oe[cyc] : 9'h0;
         if (blank.exists(cyc)) eo = eo & ~blank[cyc];
         chk_oe(eo, dq_oe);
         if (|eo) chk_dq(exp_d[cyc] & lanes(eo), dq_out & lanes(eo));
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      bl = 1;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      idle(2);
      step(CMD_MODE, 1'b0, 1'b1, 1'b0, 11'h032, '0, '0);
      idle(ctl.T_RSA);
      step(CMD_ACT, 1'b0, 1'b1, 1'b0, 11'h005, '0, '0);
      idle(ctl.T_RRD);
      step(CMD_ACT, 1'b0, 1'b1, 1'b1, 11'h009, '0, '0);
      idle(ctl.T_RCD);
      for (int p = 0; p < 4; p++) begin
         wr(p[0], p[0] ? 2 : 6, p > 1 ? 9'h1ff : 9'h0);
         nop('0);
      end
      tend("write");
      rd(1'b0, 11'h6);
      repeat (4) nop(9'(rnd()));
      idle(4);
      tend("read mask");
      rd(1'b0, 11'h6);
      rd(1'b1, 11'h2);
      idle(8);
      tend("interrupt");
      step(CMD_RD, 1'b1, 1'b1, 1'b0, 11'h6, '0, '0);
      idle(6);
      tend("select");
      step(3'h7, 1'b0, 1'b0, 1'b0, 11'h0, '0, '0);
      rd(1'b1, 11'h2);
      idle(6);
      rd(1'b1, 11'h2);
      idle(7);
      tend("clock enable");
      rd(1'b1, 11'h2);
      idle(2);
      step(CMD_PRE, 1'b0, 1'b1, 1'b0, 11'h400, '0, '0);
      idle(8);
      tend("release");
      close_out();
   end

   // Watchdog: the tests need well under 200 cycles
   initial begin
      #5000;
      n_fail++;
      close_out();
   end
endmodule
`default_nettype wire
